// *** include/dhb_map.vh ***
// Constants for the display host bus interface
`ifndef DHB_MAP_VH
`define DHB_MAP_VH

// ==========================================================================
// Interface strap codes
`define DHB_MODE_SPI4      2'h0
`define DHB_MODE_I2C       2'h1
`define DHB_MODE_M6800     2'h2
`define DHB_MODE_I8080     2'h3
`define DHB_MODE_RESET     2'h0

// ==========================================================================
// Synchroniser word layout
`define DHB_PIN_W          15
`define DHB_PIN_STRAP_HI   14
`define DHB_PIN_STRAP_LO   13
`define DHB_PIN_SEL_N      12
`define DHB_PIN_INIT_N     11
`define DHB_PIN_CMD_DATA   10
`define DHB_PIN_DIR_WR_N   9
`define DHB_PIN_STROBE_RD  8
`define DHB_PIN_IDLE       15'h1a00

// ==========================================================================
// Host bus line use in the serial modes
`define DHB_LINE_SCLK      0
`define DHB_LINE_SERIAL_DATA_IN      1
`define DHB_LINE_SDA_OUT   2

// ==========================================================================
// I2C address, upper six bits (arbitrary default)
`define DHB_I2C_ADDR_HI    6'h1e

// ==========================================================================
// Control byte fields
`define DHB_CTL_CONT_BIT   7
`define DHB_CTL_DC_BIT     6

// ==========================================================================
// Byte stream and FIFO
`define DHB_WORD_W         9
`define DHB_FIFO_DEPTH     4
`define DHB_FIFO_AW        2
`define DHB_BIT_LAST       4'h7
`define DHB_BIT_ACK        4'h8
`define DHB_STRAP_WAIT     2'h3

`endif

// *** rtl/dhb_fifo.v ***
// Small FIFO for the received command and data bytes
`timescale 1ns/1ps

`include "dhb_map.vh"

module dhb_fifo #(
  parameter WIDTH = `DHB_WORD_W,
  parameter DEPTH = `DHB_FIFO_DEPTH,
  parameter AW    = `DHB_FIFO_AW
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  input  wire             clr,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;

  wire            push;
  wire            pop;

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // ========================================================================
  // Storage
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // ========================================================================
  // Pointers; wrap relies on a power-of-two depth
  always @(posedge clk) begin
    if (!rst_n || clr) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

// *** rtl/dhb_host_port.v ***
// Host bus port of the display controller: parallel, 4-wire serial and I2C
`timescale 1ns/1ps

`include "dhb_map.vh"

// Behaviour
// R1 - Bus transfers happen only while the active-low select input is low.
// R2 - Init input low reinitialises the port; it stays high in normal use.
// R3 - Command/data input high: the byte is display data.
// R4 - Command/data input low: the byte goes to the command register.
// R5 - In I2C mode the command/data input sets the slave address low bit.
// R6 - Host holds command/data low when a three-wire serial bus is used.
// R7 - In 6800 mode the direction input high means read, low means write.
// R8 - In 6800 mode a cycle starts on enable rising while selected.
// R9 - In 8080 mode a write starts on write strobe falling while selected.
// R10 - In 8080 mode read strobe low while selected drives data onto the bus.
// R11 - Host ties the read/enable strobe low in serial and I2C modes.
// R12 - Host ties unused data lines low.
// R13 - 4-wire serial: line 0 is clock, line 1 is data in, line 2 unused.
// R14 - I2C: lines 1 and 2 form the data line, line 0 the clock.
// R15 - Strap code 10 selects the 6800 parallel bus.
// R16 - Strap 00 is 4-wire serial, 01 is I2C, 11 is 8080 parallel.
// R17 - Host init sends clock divide command 0xB3 then 0x00.
// R18 - Host init sends second pre-charge command 0xB6 then 0x0F.
// R19 - Host init sends function selection command 0xD5 then 0x62.
// R20 - Host init sends start line command 0xA1 then 0x00.
// R21 - Host sets contrast with 0x81 then 0x9B, or 0x3B for dimmer.
// R22 - Init bytes go with command/data low; display-on comes last.
// R23 - Host sets 64 byte columns and 128 rows before writing data.
module dhb_host_port (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Host pins
  input  wire [1:0] host_iface_strap,
  input  wire       bus_sel_n,
  input  wire       init_n,
  input  wire       cmd_data_sel,
  input  wire       dir_wr_n,
  input  wire       strobe_rd,
  input  wire [7:0] bus_in,
  output reg  [7:0] bus_out,
  output reg  [7:0] bus_oe,
  // Core side
  input  wire [7:0] read_data,
  output wire       core_init,
  output wire       byte_valid,
  input  wire       byte_ready,
  output wire [7:0] byte_data,
  output wire       byte_is_data,
  // Status
  output wire       accept_ready,
  output reg        overrun_r,
  output wire [1:0] active_mode
);

  // ========================================================================
  // Local constants
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ADDR = 5'h02;
  localparam [4:0] ST_CTRL = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_SKIP = 5'h10;

  // ========================================================================
  // Edge helpers on synchronised levels
  function edge_up;
    input p;
    input c;
    begin
      edge_up = ~p & c;
    end
  endfunction

  function edge_down;
    input p;
    input c;
    begin
      edge_down = p & ~c;
    end
  endfunction

  // ========================================================================
  // Pin synchronisers; only sync_r and prev_r feed logic
  wire [`DHB_PIN_W-1:0] pins;
  reg  [`DHB_PIN_W-1:0] meta_r;
  reg  [`DHB_PIN_W-1:0] sync_r;
  reg  [`DHB_PIN_W-1:0] prev_r;

  assign pins = {host_iface_strap, bus_sel_n, init_n, cmd_data_sel, dir_wr_n, strobe_rd, bus_in};

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= `DHB_PIN_IDLE;
      sync_r <= `DHB_PIN_IDLE;
      prev_r <= `DHB_PIN_IDLE;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  wire       sel     = ~sync_r[`DHB_PIN_SEL_N];
  wire       reinit  = ~sync_r[`DHB_PIN_INIT_N];
  wire       dc      = sync_r[`DHB_PIN_CMD_DATA];
  wire       dc_p    = prev_r[`DHB_PIN_CMD_DATA];
  wire       dir     = sync_r[`DHB_PIN_DIR_WR_N];
  wire       dir_p   = prev_r[`DHB_PIN_DIR_WR_N];
  wire       stb     = sync_r[`DHB_PIN_STROBE_RD];
  wire       stb_p   = prev_r[`DHB_PIN_STROBE_RD];
  wire [7:0] dat     = sync_r[7:0];
  wire [7:0] dat_p   = prev_r[7:0];
  wire       ln_clk  = dat[`DHB_LINE_SCLK];
  wire       ln_clkp = dat_p[`DHB_LINE_SCLK];
  wire       ln_sd   = dat[`DHB_LINE_SERIAL_DATA_IN];
  wire       ln_sdp  = dat_p[`DHB_LINE_SERIAL_DATA_IN];

  assign core_init = reinit; // R2

  // ========================================================================
  // Strap capture after reset release and on every reinit
  reg [1:0] mode_r;
  reg [1:0] strap_wait_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      mode_r       <= `DHB_MODE_RESET;
      strap_wait_r <= `DHB_STRAP_WAIT;
    end else begin
      if (strap_wait_r != 2'h0 || reinit) begin
        mode_r <= sync_r[`DHB_PIN_STRAP_HI:`DHB_PIN_STRAP_LO]; // R15 R16
      end
      if (strap_wait_r != 2'h0) begin
        strap_wait_r <= strap_wait_r - 2'h1;
      end
    end
  end

  assign active_mode = mode_r;

  wire m68  = (mode_r == `DHB_MODE_M6800);
  wire m80  = (mode_r == `DHB_MODE_I8080);
  wire mspi = (mode_r == `DHB_MODE_SPI4);
  wire mi2c = (mode_r == `DHB_MODE_I2C);

  // ========================================================================
  // Parallel cycle decode
  wire par_start = sel & (m68 ? edge_up(stb_p, stb)                                     // R8
                              : m80 & (edge_down(dir_p, dir) | edge_down(stb_p, stb))); // R9 R10
  wire par_read  = m68 ? dir : edge_down(stb_p, stb); // R7 R10

  reg  cyc_act_r;
  reg  cyc_read_r;

  // 8080 ends on the rise of whichever strobe opened the cycle
  wire par_end_stb = m68 ? edge_down(stb_p, stb)
                         : (cyc_read_r ? edge_up(stb_p, stb) : edge_up(dir_p, dir));
  wire par_end     = cyc_act_r & (par_end_stb | ~sel);

  // ========================================================================
  // Serial and I2C state
  reg [7:0] shift_r;
  reg [3:0] bit_cnt_r;
  reg [4:0] i2c_st_r;
  reg       ack_phase_r;
  reg       ctl_cont_r;
  reg       ctl_dc_r;
  reg       i2c_data_drive;

  wire i2c_start = sel & ln_clk & ln_clkp & edge_down(ln_sdp, ln_sd);
  wire i2c_stop  = ln_clk & ln_clkp & edge_up(ln_sdp, ln_sd);
  wire scl_up    = edge_up(ln_clkp, ln_clk);
  wire scl_down  = edge_down(ln_clkp, ln_clk);
  wire [7:0] spi_byte = {shift_r[6:0], ln_sd};

  // ========================================================================
  // FIFO feed
  reg        push_r;
  reg  [8:0] push_word_r;
  wire       fifo_in_ready;

  // A push in flight may be the one that fills the FIFO
  assign accept_ready = fifo_in_ready & ~push_r;

  // ========================================================================
  // Main sequencer
  always @(posedge clk) begin
    if (!rst_n || reinit) begin // R2
      cyc_act_r      <= 1'b0;
      cyc_read_r     <= 1'b0;
      bus_out        <= 8'h00;
      bus_oe         <= 8'h00;
      shift_r        <= 8'h00;
      bit_cnt_r      <= 4'h0;
      i2c_st_r       <= ST_IDLE;
      ack_phase_r    <= 1'b0;
      ctl_cont_r     <= 1'b0;
      ctl_dc_r       <= 1'b0;
      i2c_data_drive <= 1'b0;
      push_r         <= 1'b0;
      push_word_r    <= 9'h000;
      overrun_r      <= 1'b0;
    end else begin
      push_r <= 1'b0;
      if (m68 || m80) begin
        if (par_end) begin
          cyc_act_r <= 1'b0;
          bus_oe    <= 8'h00;
          if (!cyc_read_r && par_end_stb) begin
            // Data sampled while the strobe was still active
            push_r      <= accept_ready;
            push_word_r <= {dc_p, dat_p}; // R3 R4
            overrun_r   <= overrun_r | ~accept_ready;
          end
        end else if (par_start && !cyc_act_r) begin // R1
          cyc_act_r  <= 1'b1;
          cyc_read_r <= par_read;
          if (par_read) begin
            bus_out <= read_data;
            bus_oe  <= 8'hff; // R10
          end
        end
      end else if (mspi) begin
        bus_oe <= 8'h00;
        if (!sel) begin // R1
          bit_cnt_r <= 4'h0;
        end else if (scl_up) begin // R13
          shift_r <= spi_byte;
          if (bit_cnt_r == `DHB_BIT_LAST) begin
            bit_cnt_r   <= 4'h0;
            push_r      <= accept_ready;
            push_word_r <= {dc, spi_byte}; // R3 R4
            overrun_r   <= overrun_r | ~accept_ready;
          end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
      end else if (mi2c) begin
        // Open drain: only ever pulls the data line low
        bus_out <= 8'h00;
        bus_oe  <= {5'h00, i2c_data_drive, 2'h0}; // R14
        if (!sel || i2c_stop) begin
          i2c_st_r       <= ST_IDLE;
          i2c_data_drive <= 1'b0;
          ack_phase_r    <= 1'b0;
        end else if (i2c_start) begin
          i2c_st_r       <= ST_ADDR;
          bit_cnt_r      <= 4'h0;
          ack_phase_r    <= 1'b0;
          i2c_data_drive <= 1'b0;
        end else if (scl_up && bit_cnt_r != `DHB_BIT_ACK) begin
          shift_r   <= {shift_r[6:0], ln_sd};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (scl_down && ack_phase_r) begin
          i2c_data_drive <= 1'b0;
          ack_phase_r    <= 1'b0;
          bit_cnt_r      <= 4'h0;
        end else if (scl_down && bit_cnt_r == `DHB_BIT_ACK) begin
          ack_phase_r <= 1'b1;
          case (i2c_st_r)
            ST_ADDR: begin
              if (shift_r == {`DHB_I2C_ADDR_HI, dc, 1'b0}) begin // R5
                i2c_data_drive <= 1'b1;
                i2c_st_r       <= ST_CTRL;
              end else begin
                i2c_st_r <= ST_SKIP;
              end
            end
            ST_CTRL: begin
              ctl_cont_r     <= shift_r[`DHB_CTL_CONT_BIT];
              ctl_dc_r       <= shift_r[`DHB_CTL_DC_BIT];
              i2c_data_drive <= 1'b1;
              i2c_st_r       <= ST_DATA;
            end
            ST_DATA: begin
              // Full FIFO answers with a not-acknowledge
              if (accept_ready) begin
                push_r         <= 1'b1;
                push_word_r    <= {ctl_dc_r, shift_r}; // R3 R4
                i2c_data_drive <= 1'b1;
                i2c_st_r       <= ctl_cont_r ? ST_CTRL : ST_DATA;
              end else begin
                i2c_st_r <= ST_SKIP;
              end
            end
            default: begin
              i2c_st_r <= ST_SKIP;
            end
          endcase
        end
      end
    end
  end

  // ========================================================================
  // Byte FIFO toward the command decoder
  wire [8:0] fifo_out;

  dhb_fifo #(
    .WIDTH (`DHB_WORD_W),
    .DEPTH (`DHB_FIFO_DEPTH),
    .AW    (`DHB_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .clr       (reinit),
    .in_valid  (push_r),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word_r),
    .out_valid (byte_valid),
    .out_ready (byte_ready),
    .out_data  (fifo_out)
  );

  assign byte_data    = fifo_out[7:0];
  assign byte_is_data = fifo_out[8];

endmodule

// *** verification/dhb_checker.sv ***
// Assertions on the pins and byte stream of the host bus port
`timescale 1ns/1ps
`include "dhb_map.vh"
module dhb_checker (
  // Clock and reset
  input wire       clk,
  input wire       rst_n,
  // Host pins
  input wire       bus_sel_n,
  input wire       init_n,
  input wire       dir_wr_n,
  input wire       strobe_rd,
  input wire [7:0] bus_out,
  input wire [7:0] bus_oe,
  // Core side
  input wire [7:0] read_data,
  input wire       core_init,
  input wire       byte_valid,
  input wire       byte_ready,
  input wire [7:0] byte_data,
  input wire       byte_is_data,
  input wire [1:0] active_mode
);
  reg [2:0] quiet_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Settle count: the strap may only reload just after reset or init
  always @(posedge clk) begin
    if (!rst_n || core_init)
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  end
  // ==========================================================================
  // Properties
  property p_init; $fell(init_n) |-> ##[1:3] core_init; endproperty
  a_init: assert property (p_init) else $error("init not passed on");
  property p_desel; bus_sel_n [*5] |-> bus_oe == 8'h00; endproperty
  a_desel: assert property (p_desel) else $error("bus driven while deselected");
  property p_rd80; $fell(strobe_rd) && !bus_sel_n && active_mode == `DHB_MODE_I8080
    |-> ##[2:8] bus_oe == 8'hff && bus_out == read_data; endproperty
  a_rd80: assert property (p_rd80) else $error("8080 read not driven");
  property p_rd68; $rose(strobe_rd) && dir_wr_n && !bus_sel_n && active_mode == `DHB_MODE_M6800
    |-> ##[2:8] bus_oe == 8'hff; endproperty
  a_rd68: assert property (p_rd68) else $error("6800 read not driven");
  property p_wr80; $rose(dir_wr_n) && !bus_sel_n && !byte_valid && active_mode == `DHB_MODE_I8080
    |-> ##[2:6] byte_valid; endproperty
  a_wr80: assert property (p_wr80) else $error("8080 write lost");
  property p_i2c; active_mode == `DHB_MODE_I2C
    |-> bus_out == 8'h00 && (bus_oe == 8'h00 || bus_oe == 8'h04); endproperty
  a_i2c: assert property (p_i2c) else $error("bad drive in I2C mode");
  property p_hold; disable iff (!rst_n || core_init) byte_valid && !byte_ready
    |=> byte_valid && $stable(byte_data) && $stable(byte_is_data); endproperty
  a_hold: assert property (p_hold) else $error("stalled byte changed");
  property p_mode; disable iff (!rst_n || core_init) quiet_r == 3'h7 |=> $stable(active_mode); endproperty
  a_mode: assert property (p_mode) else $error("mode changed without init");
  c_ack: cover property (bus_oe == 8'h04);
  c_read: cover property (bus_oe == 8'hff);
  c_pop: cover property (byte_valid && byte_ready);
endmodule

bind dhb_host_port dhb_checker dhb_checker_i (.clk, .rst_n, .bus_sel_n, .init_n, .dir_wr_n, .strobe_rd,
  .bus_out, .bus_oe, .read_data, .core_init, .byte_valid, .byte_ready, .byte_data, .byte_is_data, .active_mode);

// *** verification/dhb_host_model.sv ***
// Microcontroller model driving the host bus pins
`timescale 1ns/1ps
`include "dhb_map.vh"
module dhb_host_model (
  // Clock and what the host sees on the wires
  input wire       clk,
  input wire       sda_seen,
  input wire [7:0] bus_seen,
  // Host pins
  output reg [1:0] host_iface_strap = 2'h0,
  output reg       bus_sel_n = 1'b1,
  output reg       init_n = 1'b1,
  output reg       cmd_data_sel = 1'b0,
  output reg       dir_wr_n = 1'b1,
  output reg       strobe_rd = 1'b0,
  output reg [7:0] host_bus = 8'h00
);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ==========================================================================
  // Strap a bus type and pulse init so the port reloads it
  task automatic set_mode(input [1:0] m, input sa0);
    @(posedge clk);
    host_iface_strap <= m;
    cmd_data_sel     <= sa0;
    strobe_rd        <= (m == `DHB_MODE_I8080);
    dir_wr_n         <= 1'b1;
    host_bus         <= (m == `DHB_MODE_I2C) ? 8'h03 : 8'h00;
    init_n           <= 1'b0;
    cyc(6);
    init_n <= 1'b1;
    cyc(8);
  endtask
  // One parallel cycle, ctl is {6800, read, select_n, dc}
  task automatic par(input [3:0] ctl, input [7:0] d, output [7:0] q);
    @(posedge clk);
    bus_sel_n    <= ctl[1];
    cmd_data_sel <= ctl[0];
    host_bus     <= d;
    if (ctl[3])
      dir_wr_n <= ctl[2];
    cyc(4);
    if (ctl[3])
      strobe_rd <= 1'b1;
    else if (ctl[2])
      strobe_rd <= 1'b0;
    else
      dir_wr_n <= 1'b0;
    cyc(8);
    q = bus_seen;
    strobe_rd <= !ctl[3];
    if (!ctl[3])
      dir_wr_n <= 1'b1;
    cyc(4);
    // Held data gone: show its inverse so late sampling is caught
    host_bus  <= ~d;
    bus_sel_n <= 1'b1;
    cyc(4);
  endtask
  // 4-wire byte, clock idles low between frames
  task automatic spi(input dc, input [7:0] d);
    @(posedge clk);
    bus_sel_n    <= 1'b0;
    cmd_data_sel <= dc;
    for (int i = 7; i >= 0; i--) begin
      host_bus <= {6'h00, d[i], 1'b0};
      cyc(4);
      host_bus[0] <= 1'b1;
      cyc(4);
    end
    host_bus <= {6'h00, ~d[0], 1'b0};
    cyc(4);
    bus_sel_n <= 1'b1;
    cyc(4);
  endtask
  // Start, n bytes from the top of b each with a ninth clock for the answer, stop
  task automatic i2c_xfer(input [39:0] b, input int n, output ack);
    reg [8:0] bits;
    ack = 1'b1;
    @(posedge clk);
    bus_sel_n <= 1'b0;
    cyc(4);
    host_bus[1] <= 1'b0;
    cyc(4);
    for (int k = 0; k < n; k++) begin
      bits = {b[39-8*k -: 8], 1'b1};
      for (int i = 8; i >= 0; i--) begin
        host_bus[0] <= 1'b0;
        cyc(2);
        host_bus[1] <= bits[i];
        cyc(2);
        host_bus[0] <= 1'b1;
        cyc(2);
        if (i == 0)
          ack = ack & !sda_seen;
        cyc(2);
      end
    end
    host_bus[0] <= 1'b0;
    cyc(2);
    host_bus[1] <= 1'b0;
    cyc(2);
    host_bus[0] <= 1'b1;
    cyc(2);
    host_bus[1] <= 1'b1;
    cyc(4);
    // Deselect long enough for the port to see it before the next frame
    bus_sel_n <= 1'b1;
    cyc(4);
  endtask
endmodule

// *** verification/test_dhb_host_port.sv ***
// Self-checking bench for the host bus port
`timescale 1ns/1ps
`include "dhb_map.vh"
module test_dhb_host_port;
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg        byte_ready = 1'b0;
  reg  [7:0] read_data = 8'h00;
  wire [1:0] host_iface_strap, active_mode;
  wire       bus_sel_n, init_n, cmd_data_sel, dir_wr_n, strobe_rd, sda;
  wire [7:0] host_bus, bus_in, bus_out, bus_oe, byte_data;
  wire       core_init, byte_valid, byte_is_data, accept_ready, overrun_r;
  int        errors = 0;
  int        checks = 0;
  reg  [7:0] q;
  reg        ack;
  always #12.5 clk = ~clk;
  // Open-drain data line in I2C, otherwise whoever enables drives
  assign sda    = host_bus[1] & ~bus_oe[2];
  assign bus_in = (host_iface_strap == `DHB_MODE_I2C) ? {host_bus[7:3], sda, sda, host_bus[0]}
                : (bus_oe & bus_out) | (~bus_oe & host_bus);
  dhb_host_model dhb_host_model_i (.clk, .sda_seen(sda), .bus_seen(bus_in), .host_iface_strap, .bus_sel_n,
    .init_n, .cmd_data_sel, .dir_wr_n, .strobe_rd, .host_bus);
  dhb_host_port dhb_host_port_i (.clk, .rst_n, .host_iface_strap, .bus_sel_n, .init_n, .cmd_data_sel,
    .dir_wr_n, .strobe_rd, .bus_in, .bus_out, .bus_oe, .read_data, .core_init, .byte_valid, .byte_ready,
    .byte_data, .byte_is_data, .accept_ready, .overrun_r, .active_mode);
  // ==========================================================================
  // Compare and handshake helpers
  task automatic chk_bit(input logic a, input logic e);
    checks++;
    if (a !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, a, e);
    end
  endtask
  task automatic chk_val(input logic [8:0] a, input logic [8:0] e);
    checks++;
    if (a !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, a, e);
    end
  endtask
  task automatic pop(input logic [8:0] e);
    int n;
    n = 0;
    @(negedge clk);
    while (byte_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk_bit(byte_valid, 1'b1);
    chk_val({byte_is_data, byte_data}, e);
    @(posedge clk);
    byte_ready <= 1'b1;
    @(posedge clk);
    byte_ready <= 1'b0;
  endtask
  task automatic mode(input logic [1:0] m, input logic sa0);
    dhb_host_model_i.set_mode(m, sa0);
    @(negedge clk);
    chk_val({7'h00, active_mode}, {7'h00, m});
    chk_bit(byte_valid, 1'b0);
    chk_bit(overrun_r, 1'b0);
    chk_bit(core_init, 1'b0);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic s_i8080;
    mode(`DHB_MODE_I8080, 1'b0);
    dhb_host_model_i.par(4'h0, 8'hb3, q);
    dhb_host_model_i.par(4'h0, 8'h00, q);
    dhb_host_model_i.par(4'h1, 8'h5a, q);
    pop(9'h0b3);
    pop(9'h000);
    pop(9'h15a);
    read_data <= 8'hc3;
    dhb_host_model_i.par(4'h4, 8'h3c, q);
    chk_val({1'b0, q}, 9'h0c3);
    dhb_host_model_i.par(4'h3, 8'h77, q);
    repeat (8) @(negedge clk);
    chk_bit(byte_valid, 1'b0);
  endtask
  task automatic s_m6800;
    mode(`DHB_MODE_M6800, 1'b0);
    dhb_host_model_i.par(4'h8, 8'hb6, q);
    dhb_host_model_i.par(4'h8, 8'h0f, q);
    pop(9'h0b6);
    pop(9'h00f);
    read_data <= 8'h96;
    dhb_host_model_i.par(4'hc, 8'h69, q);
    chk_val({1'b0, q}, 9'h096);
  endtask
  task automatic s_spi;
    mode(`DHB_MODE_SPI4, 1'b0);
    dhb_host_model_i.spi(1'b0, 8'hd5);
    dhb_host_model_i.spi(1'b0, 8'h62);
    dhb_host_model_i.spi(1'b1, 8'ha5);
    chk_val({1'b0, bus_oe}, 9'h000);
    pop(9'h0d5);
    pop(9'h062);
    pop(9'h1a5);
  endtask
  // Fill past depth with the core stalled, then drain in order
  task automatic s_fifo;
    logic [39:0] seq;
    seq = 40'h81_9b81_3ba1;
    mode(`DHB_MODE_I8080, 1'b0);
    for (int i = 0; i < 5; i++) begin
      if (i == 4)
        chk_bit(accept_ready, 1'b0);
      dhb_host_model_i.par(4'h0, seq[39-8*i -: 8], q);
    end
    @(negedge clk);
    chk_bit(overrun_r, 1'b1);
    for (int i = 0; i < 4; i++)
      pop({1'b0, seq[39-8*i -: 8]});
    @(negedge clk);
    chk_bit(byte_valid, 1'b0);
  endtask
  // Address match and miss, then window commands and one data byte
  task automatic s_i2c;
    logic [7:0] a;
    a = {`DHB_I2C_ADDR_HI, 1'b1, 1'b0};
    mode(`DHB_MODE_I2C, 1'b1);
    dhb_host_model_i.i2c_xfer({a, 32'h0000_0000}, 1, ack);
    chk_bit(ack, 1'b1);
    dhb_host_model_i.i2c_xfer({`DHB_I2C_ADDR_HI, 2'h0, 32'h0000_0000}, 1, ack);
    chk_bit(ack, 1'b0);
    dhb_host_model_i.i2c_xfer({a, 32'h0015_003f}, 5, ack);
    chk_bit(ack, 1'b1);
    pop(9'h015);
    pop(9'h000);
    pop(9'h03f);
    dhb_host_model_i.i2c_xfer({a, 32'h0075_007f}, 5, ack);
    chk_bit(ack, 1'b1);
    pop(9'h075);
    pop(9'h000);
    pop(9'h07f);
    dhb_host_model_i.i2c_xfer({a, 32'h405a_0000}, 3, ack);
    chk_bit(ack, 1'b1);
    pop(9'h15a);
  endtask
  // ==========================================================================
  // Run control
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    s_i8080;
    s_m6800;
    s_spi;
    s_fifo;
    s_i2c;
    report_and_stop;
  end
  // Whole run is near 2000 cycles; ten times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop;
  end
endmodule
